// *** tb/slla_rx_model.sv ***
// receiver partner: drives the sync request, captures the sync header stream,
// models one lane of elastic buffering and its release point
// assumes the transmit framing outputs arrive on the same clock
module slla_rx_model #(
    parameter int ERR_LIMIT = 2,
    // release delay in frames, picked clear of the lane arrival spread
    parameter int RBD = 1
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control and framing in
    input wire logic i_req_sync,
    input wire logic i_blk_start,
    input wire logic i_emb_start,
    input wire logic i_shs_bit,
    input wire logic i_lmfc_edge,
    input wire logic i_ilas,
    // observations
    output logic o_sync_n,
    output logic [31:0] o_mb_word,
    output logic [7:0] o_mb_cnt,
    output logic [7:0] o_err_cnt,
    output logic o_sync_lost,
    output logic o_buffering,
    output logic o_released,
    output logic o_sysref_req
);
    logic [31:0] sr_reg;
    logic [5:0] nblk_reg;
    logic ilas_d_reg;
    logic [7:0] since_reg;
    logic rel_point;
    // release point: the clock edge itself at zero delay, else that many frames on
    assign rel_point = i_blk_start && (i_lmfc_edge ? (RBD == 0) : (since_reg == 8'(RBD)));
    // lost framing asks for sysref before realigning
    assign o_sysref_req = o_sync_lost;
    // single errors tolerated, repeated ones mean lost alignment
    assign o_sync_lost = (o_err_cnt >= 8'(ERR_LIMIT));
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sync_n <= 1'b1;
            sr_reg <= 32'h0000_0000;
            nblk_reg <= 6'h00;
            o_mb_word <= 32'h0000_0000;
            o_mb_cnt <= 8'h00;
            o_err_cnt <= 8'h00;
            ilas_d_reg <= 1'b0;
            since_reg <= 8'h00;
            o_buffering <= 1'b0;
            o_released <= 1'b0;
        end else begin
            o_sync_n <= !i_req_sync;
            ilas_d_reg <= i_ilas;
            if (i_lmfc_edge) begin
                since_reg <= 8'h01;
            end else if (i_blk_start) begin
                since_reg <= since_reg + 8'h01;
            end
            if (i_req_sync) begin
                o_buffering <= 1'b0;
                o_released <= 1'b0;
            end else begin
                // one lane only, so all lanes are in once this one is
                if ((i_ilas && !ilas_d_reg)
                        || (i_emb_start && o_mb_cnt != 8'h00 && !o_sync_lost)) begin
                    o_buffering <= 1'b1;
                end
                if (o_buffering && rel_point) begin
                    o_released <= 1'b1;
                end
            end
            if (i_blk_start) begin
                sr_reg <= {sr_reg[30:0], i_shs_bit};
            end
            if (i_emb_start) begin
                nblk_reg <= 6'h01;
                if (nblk_reg == 6'h20) begin
                    o_mb_word <= sr_reg;
                    o_mb_cnt <= o_mb_cnt + 8'h01;
                    // pilot at the tail, end bit nine places back
                    if (sr_reg[4:0] != 5'h01 || !sr_reg[9]) begin
                        o_err_cnt <= o_err_cnt + 8'h01;
                    end
                end
            end else if (i_blk_start && nblk_reg != 6'h00 && nblk_reg != 6'h20) begin
                nblk_reg <= nblk_reg + 6'h01;
            end
        end
    end
endmodule

// *** tb/slla_top_test.sv ***
// testbench for the transmit lane framing block
// assumes slla_rx_model as the receiving end
`include "slla_map.svh"
module slla_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import slla_pkg::*;
    logic clk_sys, rst_n, link_enable, mode_66, subclass1, sysref, block_tick, req_sync;
    logic [4:0] k_m1;
    logic [3:0] pe_set;
    logic sync_n, shs_bit, blk_start, emb_start, lmfc_edge, send_k, send_ilas, data_valid;
    logic ser_pwr, clk_gate, sync_lost;
    logic buffering, released, sysref_req;
    logic [1:0] sync_hdr;
    logic [`SLLA_PE_STEPS-1:0] preemph;
    logic [31:0] mb_word;
    logic [7:0] mb_cnt, err_cnt;
    slla_state_t state;
    int n_mismatch = 0;
    int compares = 0;
    slla_top i_slla_top (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_link_enable(link_enable),
        .i_mode_66(mode_66), .i_subclass1(subclass1), .i_k_m1(k_m1),
        .i_serializer_preemphasis_level(pe_set), .i_sysref(sysref), .i_block_tick(block_tick),
        .i_sync_n(sync_n), .o_sync_hdr(sync_hdr), .o_shs_bit(shs_bit), .o_blk_start(blk_start),
        .o_emb_start(emb_start), .o_lmfc_edge(lmfc_edge), .o_send_k(send_k),
        .o_send_ilas(send_ilas), .o_data_valid(data_valid), .o_state(state),
        .o_ser_power_on(ser_pwr), .o_clk_gate_en(clk_gate), .o_preemph_level(preemph));
    slla_rx_model i_slla_rx_model (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .i_req_sync(req_sync), .i_blk_start(blk_start), .i_emb_start(emb_start),
        .i_shs_bit(shs_bit), .i_lmfc_edge(lmfc_edge), .i_ilas(send_ilas),
        .o_sync_n(sync_n), .o_mb_word(mb_word), .o_mb_cnt(mb_cnt),
        .o_err_cnt(err_cnt), .o_sync_lost(sync_lost), .o_buffering(buffering),
        .o_released(released), .o_sysref_req(sysref_req));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_st(input slla_state_t exp);
        compares++;
        if (state !== exp) begin
            n_mismatch++;
            $display("ERROR state expected %0d seen %0d", exp, state);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        block_tick = 1'b0;
        repeat (n) @(negedge clk_sys);
    endtask
    // tick stays up into a following tick, cyc drops it; returns where its answer is visible
    task automatic tick();
        block_tick = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic t_66();
        int ones[6] = '{3, 11, 19, 21, 22, 31};
        logic [31:0] exp_w;
        exp_w = 32'h0000_0000;
        foreach (ones[j]) exp_w[31 - ones[j]] = 1'b1;
        mode_66 = 1'b1;
        link_enable = 1'b1;
        cyc(1);
        chk_st(SLLA_DATA);
        chk("ser_pwr", 1, ser_pwr);
        chk("clk_gate", 1, clk_gate);
        for (int i = 0; i < 65; i++) begin
            tick();
            chk("emb_start", i % 32 == 0, emb_start);
            chk("lmfc_edge", i % 32 == 0, lmfc_edge);
            chk("hdr", exp_w[31 - i % 32] ? `SLLA_HDR_ONE : `SLLA_HDR_ZERO, sync_hdr);
            chk("shs_bit", exp_w[31 - i % 32], shs_bit);
            chk("send_ilas", 0, send_ilas);
        end
        // receiver takes the last multiblock start one cycle later
        cyc(1);
        chk("mb_cnt", 2, mb_cnt);
        chk("err_cnt", 0, err_cnt);
        chk("sync_lost", 0, sync_lost);
        chk("mb_word", exp_w, mb_word);
        chk("buffering", 1, buffering);
        chk("released", 0, released);
        chk("sysref_req", 0, sysref_req);
    endtask
    task automatic t_sysref();
        tick();
        tick();
        sysref = 1'b1;
        cyc(1);
        chk("released", 1, released);
        tick();
        chk("lmfc_edge", 1, lmfc_edge);
        chk("emb_start", 1, emb_start);
        sysref = 1'b0;
        subclass1 = 1'b0;
        tick();
        sysref = 1'b1;
        cyc(1);
        tick();
        chk("lmfc_edge", 0, lmfc_edge);
        sysref = 1'b0;
    endtask
    task automatic t_disable();
        link_enable = 1'b0;
        cyc(1);
        chk_st(SLLA_OFF);
        chk("ser_pwr", 0, ser_pwr);
        chk("clk_gate", 0, clk_gate);
        tick();
        chk("blk_start", 0, blk_start);
        mode_66 = 1'b0;
    endtask
    task automatic t_8b10b();
        k_m1 = 5'h03;
        req_sync = 1'b1;
        cyc(2);
        link_enable = 1'b1;
        cyc(1);
        chk_st(SLLA_CGS);
        chk("send_k", 1, send_k);
        req_sync = 1'b0;
        cyc(2);
        chk_st(SLLA_ILAS_WAIT);
        chk("buffering", 0, buffering);
        for (int i = 0; i < 16; i++) begin
            tick();
            chk_st(i == 15 ? SLLA_DATA : SLLA_ILAS);
            chk("send_ilas", i != 15, send_ilas);
        end
        chk("data_valid", 1, data_valid);
        chk("buffering", 1, buffering);
        chk("released", 1, released);
        req_sync = 1'b1;
        cyc(2);
        chk_st(SLLA_CGS);
    endtask
    task automatic t_preemph();
        for (int s = 0; s < 16; s++) begin
            pe_set = 4'(s);
            cyc(1);
            chk("preemph", (32'h0000_0001 << s) - 1, 32'(preemph));
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end
    initial begin
        {rst_n, link_enable, mode_66, sysref, req_sync} = 5'h00;
        subclass1 = 1'b1;
        k_m1 = 5'h00;
        pe_set = 4'h0;
        cyc(10);
        rst_n = 1'b1;
        cyc(1);
        chk_st(SLLA_OFF);
        chk("ser_pwr", 0, ser_pwr);
        t_66();
        t_sysref();
        t_disable();
        t_8b10b();
        t_preemph();
        summarize();
    end
endmodule

// *** verilog/slla_map.svh ***
// constants for the transmit lane framing and alignment block
// assumes one block or frame tick per cycle at most, from the serializer side
`ifndef SLLA_MAP_SVH
`define SLLA_MAP_SVH

// index of the last block of a multiblock (32 blocks)
`define SLLA_MB_LAST_IDX 5'h1f
// multiblocks per extended multiblock, fixed at one
`define SLLA_MB_PER_EMB 1
// sync header stream bits that are always one (3, 11, 19, 21, 31)
`define SLLA_SHS_ONES 32'h8028_0808
// position of the end-of-extended-multiblock bit
`define SLLA_SHS_EOEMB_POS 5'h16
// index of the last alignment sequence multiframe (four in all)
`define SLLA_ILAS_LAST_MF 2'h3
// sync headers of a 64b/66b block
`define SLLA_HDR_ONE 2'h2
`define SLLA_HDR_ZERO 2'h1
`define SLLA_HDR_IDLE 2'h0
// pre-emphasis steps
`define SLLA_PE_STEPS 15

`endif

// *** verilog/slla_pkg.sv ***
// types of the transmit lane framing and alignment block
// assumes slla_map.svh on the include path
package slla_pkg;
    `include "slla_map.svh"

    typedef enum logic [2:0] {
        SLLA_OFF,
        SLLA_CGS,
        SLLA_ILAS_WAIT,
        SLLA_ILAS,
        SLLA_DATA
    } slla_state_t;

    typedef struct packed {
        slla_state_t st;
        logic [1:0] hdr;
        logic shs_bit;
        logic blk_start;
        logic emb_start;
        logic lmfc_edge;
        logic send_k;
        logic send_ilas;
        logic data_valid;
        logic [1:0] ilas_cnt;
        logic sysref_d;
        logic pwr;
        logic clkg;
        logic [`SLLA_PE_STEPS-1:0] pe;
    } slla_regs_t;
endpackage

// *** verilog/slla_pos_counter.sv ***
// position counter within a multiframe or multiblock
// assumes a one-cycle tick enable and a synchronous clear
module slla_pos_counter (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [4:0] i_last,
    // position
    output logic [4:0] o_count
);
    logic [4:0] count_reg;
    logic [4:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (i_clear) begin
            count_next = 5'h0;
        end else if (i_tick) begin
            count_next = (count_reg >= i_last) ? 5'h0 : count_reg + 5'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            count_reg <= 5'h0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign o_count = count_reg;
endmodule

// *** verilog/slla_top.sv ***
// transmit-end lane framing: sync headers, sync header stream,
// multiframe / extended multiblock clock, link start-up sequencing
// assumes synchronous inputs and a block or frame tick from the serializer
`include "slla_map.svh"

// How it works
// - 64b/66b sends no alignment sequence
// - every 64b/66b block starts with header transition
// - pre-emphasis grows monotonically with setting
// - disabled link held reset, powered down
// - sysref resets multiframe or multiblock clock
// - this end only transmits
// - subclass 0 free-runs without sysref
// - 8b/10b sync request starts code groups, sequence
// - end-of-extended bit set on last only
// - one multiblock per extended multiblock
module slla_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // configuration
    input wire logic i_link_enable,
    input wire logic i_mode_66,
    input wire logic i_subclass1,
    input wire logic [4:0] i_k_m1,
    input wire logic [3:0] i_serializer_preemphasis_level,
    // timing and receiver request
    input wire logic i_sysref,
    input wire logic i_block_tick,
    input wire logic i_sync_n,
    // framing outputs
    output logic [1:0] o_sync_hdr,
    output logic o_shs_bit,
    output logic o_blk_start,
    output logic o_emb_start,
    output logic o_lmfc_edge,
    // sequencing outputs
    output logic o_send_k,
    output logic o_send_ilas,
    output logic o_data_valid,
    output slla_pkg::slla_state_t o_state,
    // physical layer controls
    output logic o_ser_power_on,
    output logic o_clk_gate_en,
    output logic [`SLLA_PE_STEPS-1:0] o_preemph_level
);
    import slla_pkg::*;

    slla_regs_t r_reg;
    slla_regs_t r_next;
    logic [4:0] pos;
    logic [4:0] pos_last;
    logic tick;
    logic sysref_edge;
    logic pos_clear;
    logic emb_last;
    logic stream_bit;

    assign tick = i_block_tick & i_link_enable;
    assign sysref_edge = i_sysref & ~r_reg.sysref_d & i_subclass1;
    assign pos_clear = ~i_link_enable | sysref_edge;
    assign pos_last = i_mode_66 ? `SLLA_MB_LAST_IDX : i_k_m1;
    assign emb_last = (`SLLA_MB_PER_EMB == 1);
    assign stream_bit = (((`SLLA_SHS_ONES >> pos) & 32'h0000_0001) != 32'h0000_0000)
        | ((pos == `SLLA_SHS_EOEMB_POS) & emb_last);

    slla_pos_counter u_pos (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clear(pos_clear),
        .i_tick(tick),
        .i_last(pos_last),
        .o_count(pos)
    );

    always_comb begin
        r_next = r_reg;
        r_next.blk_start = 1'b0;
        r_next.emb_start = 1'b0;
        r_next.lmfc_edge = 1'b0;
        r_next.sysref_d = i_sysref;
        r_next.pwr = i_link_enable;
        r_next.clkg = i_link_enable;
        for (int i = 0; i < `SLLA_PE_STEPS; i++) begin
            r_next.pe[i] = (4'(i) < i_serializer_preemphasis_level);
        end
        if (!i_link_enable) begin
            r_next.st = SLLA_OFF;
            r_next.hdr = `SLLA_HDR_IDLE;
            r_next.shs_bit = 1'b0;
            r_next.ilas_cnt = 2'h0;
        end else begin
            if (tick) begin
                r_next.blk_start = 1'b1;
                r_next.lmfc_edge = (pos == 5'h0);
                r_next.emb_start = i_mode_66 & (pos == 5'h0);
                r_next.shs_bit = i_mode_66 & stream_bit;
                if (i_mode_66) begin
                    r_next.hdr = stream_bit ? `SLLA_HDR_ONE : `SLLA_HDR_ZERO;
                end else begin
                    r_next.hdr = `SLLA_HDR_IDLE;
                end
            end
            case (r_reg.st)
                SLLA_OFF: begin
                    r_next.st = i_mode_66 ? SLLA_DATA : SLLA_CGS;
                end
                SLLA_CGS: begin
                    if (i_sync_n) begin
                        r_next.st = SLLA_ILAS_WAIT;
                    end
                end
                SLLA_ILAS_WAIT: begin
                    if (!i_sync_n) begin
                        r_next.st = SLLA_CGS;
                    end else if (tick && pos == 5'h0) begin
                        r_next.st = SLLA_ILAS;
                        r_next.ilas_cnt = 2'h0;
                    end
                end
                SLLA_ILAS: begin
                    if (!i_sync_n) begin
                        r_next.st = SLLA_CGS;
                    end else if (tick && pos == pos_last) begin
                        r_next.ilas_cnt = r_reg.ilas_cnt + 2'h1;
                        if (r_reg.ilas_cnt == `SLLA_ILAS_LAST_MF) begin
                            r_next.st = SLLA_DATA;
                        end
                    end
                end
                SLLA_DATA: begin
                    if (!i_mode_66 && !i_sync_n) begin
                        r_next.st = SLLA_CGS;
                    end
                end
                default: begin
                    r_next.st = SLLA_OFF;
                end
            endcase
        end
        r_next.send_k = (r_next.st == SLLA_CGS) || (r_next.st == SLLA_ILAS_WAIT);
        r_next.send_ilas = (r_next.st == SLLA_ILAS);
        r_next.data_valid = (r_next.st == SLLA_DATA);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_sync_hdr = r_reg.hdr;
    assign o_shs_bit = r_reg.shs_bit;
    assign o_blk_start = r_reg.blk_start;
    assign o_emb_start = r_reg.emb_start;
    assign o_lmfc_edge = r_reg.lmfc_edge;
    assign o_send_k = r_reg.send_k;
    assign o_send_ilas = r_reg.send_ilas;
    assign o_data_valid = r_reg.data_valid;
    assign o_state = r_reg.st;
    assign o_ser_power_on = r_reg.pwr;
    assign o_clk_gate_en = r_reg.clkg;
    assign o_preemph_level = r_reg.pe;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    AST_NO_ILAS_66: assert property (
        i_mode_66 && $past(i_mode_66) |-> !o_send_ilas && !o_send_k)
        else $error("alignment sequence sent in 64b/66b mode");
    AST_HDR_TRANSITION: assert property (
        o_blk_start && $past(i_mode_66) |-> o_sync_hdr[1] != o_sync_hdr[0])
        else $error("block header without transition");
    AST_HDR_CARRIES_BIT: assert property (
        o_blk_start && $past(i_mode_66) |-> o_sync_hdr[1] == o_shs_bit)
        else $error("header does not carry stream bit");
    AST_EOEMB_SET: assert property (
        tick && i_mode_66 && pos == `SLLA_SHS_EOEMB_POS |=> o_shs_bit)
        else $error("end-of-extended-multiblock bit clear");
    AST_PILOT_TAIL: assert property (
        tick && i_mode_66 && pos == `SLLA_MB_LAST_IDX |=> o_shs_bit && o_blk_start)
        else $error("pilot end bit missing");
    AST_PILOT_ZEROS: assert property (
        tick && i_mode_66 && pos > 5'h1a && pos < `SLLA_MB_LAST_IDX |=> !o_shs_bit)
        else $error("pilot zero run broken");
    AST_DISABLED_OFF: assert property (
        !i_link_enable |=> !o_ser_power_on && !o_clk_gate_en && !o_data_valid
            && o_state == SLLA_OFF)
        else $error("link active while disabled");
    AST_ENABLED_ON: assert property (
        i_link_enable |=> o_ser_power_on && o_clk_gate_en)
        else $error("link not powered when enabled");
    AST_PE_MONOTONIC: assert property (
        ((o_preemph_level + 15'h0001) & o_preemph_level) == 15'h0000)
        else $error("pre-emphasis not thermometer coded");
    AST_PE_TRACKS: assert property (
        $past(i_serializer_preemphasis_level) != 4'h0 |-> o_preemph_level[0])
        else $error("pre-emphasis ignores setting");
    AST_SYSREF_RESET: assert property (
        i_link_enable && sysref_edge |=> pos == 5'h0)
        else $error("sysref did not reset clock");
    AST_SUB0_FREE: assert property (
        !i_subclass1 && i_link_enable && tick && pos < pos_last |=> pos == $past(pos) + 5'h1)
        else $error("subclass 0 clock disturbed");
    AST_SYNC_CGS: assert property (
        i_link_enable && !i_mode_66 && !i_sync_n |=> o_send_k)
        else $error("sync request did not start code groups");
endmodule
